/* logic/fwec_pkg.sv */
// How it works
// - host waits busy delay before polling
// - host holds unlock until status valid
// - host holds address stable through each operation
// - wait 1000 ns after reset release
// - write or chip-select strobe controls cycle
package fwec_pkg;
  localparam int CLK_MHZ        = 25;           // system clock rate
  localparam int CLK_NS         = 40;           // clock period in ns
  localparam int BUSY_DLY_NS    = 200;          // strobe end to busy status
  localparam int RST_REC_NS     = 1000;         // reset high to strobe low
  localparam int PGM_MIN_US     = 6;            // least program duration
  localparam int SMALL_ERA_MS   = 300;          // least boot/parameter erase
  localparam int MAIN_ERA_MS    = 600;          // least main erase
  localparam int SMALL_ERA_MAXS = 7;            // longest boot/parameter erase
  localparam int MAIN_ERA_MAXS  = 14;           // longest main erase
  localparam int UNLOCK_SU_NS   = 200;          // unlock setup to strobe end
  localparam int STROBE_NS      = 70;           // strobe low width
  localparam int STROBE_HI_NS   = 30;           // strobe high width
  // cycle counts: least times round up
  localparam int BUSY_DLY_CYC  = (BUSY_DLY_NS + CLK_NS - 1) / CLK_NS;
  localparam int RST_REC_CYC   = (RST_REC_NS + CLK_NS - 1) / CLK_NS;
  localparam int UNLOCK_SU_CYC = (UNLOCK_SU_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_CYC    = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam int STROBE_HI_CYC = (STROBE_HI_NS + CLK_NS - 1) / CLK_NS;
  localparam int PGM_MIN_CYC   = PGM_MIN_US * CLK_MHZ;
  // longest times round down
  localparam longint SMALL_TMO_CYC = longint'(SMALL_ERA_MAXS) * CLK_MHZ * 1000000;
  localparam longint MAIN_TMO_CYC  = longint'(MAIN_ERA_MAXS) * CLK_MHZ * 1000000;
  localparam longint PGM_TMO_CYC   = longint'(SMALL_ERA_MAXS) * CLK_MHZ * 1000000;
  localparam int     STAT_DONE_BIT = 7;         // completion_status_bit position
  localparam logic [7:0] CMD_PROGRAM = 8'h40;   // program setup command
  localparam logic [7:0] CMD_ERASE   = 8'h20;   // erase setup command
  localparam logic [7:0] CMD_CONFIRM = 8'hD0;   // erase confirm command
  localparam logic [7:0] CMD_STATUS  = 8'h70;   // read status command
  localparam logic [7:0] CMD_CLRSTAT = 8'h50;   // clear status command
  localparam logic [7:0] CMD_READ    = 8'hFF;   // back to array read
  // host operation kinds
  typedef enum logic [1:0] {FWEC_PROGRAM, FWEC_ERASE_SMALL, FWEC_ERASE_MAIN} fwec_op_t;
endpackage : fwec_pkg

/* logic/fwec_cyc_if.sv */
`timescale 1ns/10ps
// one bus cycle request from sequencer to strobe engine
interface fwec_cyc_if;
  logic        req;       // start a cycle
  logic        isWrite;   // write when high, read when low
  logic [15:0] wdata;     // data to drive
  logic        done;      // one-cycle pulse at cycle end
  logic [15:0] rdata;     // captured read data
  modport seq (output req, output isWrite, output wdata, input done, input rdata);
  modport eng (input req, input isWrite, input wdata, output done, output rdata);
endinterface : fwec_cyc_if

/* logic/fwec_strobe.sv */
`timescale 1ns/10ps
// drives one write or read cycle on the flash pins
module fwec_strobe #(
  parameter int DW = 16
) (
  input  wire logic          clk,
  input  wire logic          reset,
  fwec_cyc_if.eng            cyc,
  input  wire logic          useChipSel,
  output logic               chipSelN,
  output logic               writeEnN,
  output logic               outEnN,
  output logic [DW-1:0]      dataOut,
  output logic               dataOe,
  input  wire logic [DW-1:0] dataIn
);
  typedef enum logic [1:0] {FWEC_S_IDLE, FWEC_S_LOW, FWEC_S_HIGH} fwec_sst_t;
  fwec_sst_t state;                // strobe phase
  logic [3:0] cnt;                 // phase timer
  logic       isWr;                // cycle kind latched at start
  logic       active;              // strobe low phase

  // strobe phases: low width then high recovery
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state <= FWEC_S_IDLE;
      cnt   <= 4'h0;
      isWr  <= 1'b0;
    end else begin
      unique case (state)
        FWEC_S_IDLE: begin
          if (cyc.req) begin
            state <= FWEC_S_LOW;
            isWr  <= cyc.isWrite;
            cnt   <= 4'(fwec_pkg::STROBE_CYC - 1);
          end
        end
        FWEC_S_LOW: begin
          if (cnt == 4'h0) begin
            state <= FWEC_S_HIGH;
            cnt   <= 4'(fwec_pkg::STROBE_HI_CYC - 1);
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        FWEC_S_HIGH: begin
          if (cnt == 4'h0) begin
            state <= FWEC_S_IDLE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
      endcase
    end
  end

  assign active = (state == FWEC_S_LOW);

  // strobe form choice: write strobe stays low across chip-select in the
  // chip-select form, so chip-select edges end the cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      chipSelN <= 1'b1;
      writeEnN <= 1'b1;
      outEnN   <= 1'b1;
    end else begin
      chipSelN <= !(cyc.req && state == FWEC_S_IDLE) && !(active && cnt != 4'h0);
      // chip-select form keeps the write strobe low one cycle past chip select
      writeEnN <= !((cyc.req && state == FWEC_S_IDLE && cyc.isWrite) ||
                    (active && isWr && (cnt != 4'h0 || useChipSel)));
      outEnN   <= !((cyc.req && state == FWEC_S_IDLE && !cyc.isWrite) ||
                    (active && cnt != 4'h0 && !isWr));
    end
  end

  // data bus drive and read capture
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      dataOut   <= '0;
      dataOe    <= 1'b0;
      cyc.rdata <= 16'h0000;
    end else begin
      if (cyc.req && state == FWEC_S_IDLE) begin
        dataOut <= cyc.wdata[DW-1:0];
        dataOe  <= cyc.isWrite;
      end else if (state == FWEC_S_HIGH) begin
        dataOe <= 1'b0;
      end
      if (active && cnt == 4'h0 && !isWr) begin
        cyc.rdata <= 16'(dataIn);
      end
    end
  end

  assign cyc.done = (state == FWEC_S_HIGH) && (cnt == 4'h0);

  // chip-select pulse is exactly two cycles wide
  property p_strobe_width;
    @(posedge clk) disable iff (reset)
      $fell(chipSelN) |-> !chipSelN [*2] ##1 chipSelN;
  endproperty
  a_strobe_width: assert property (p_strobe_width)
    else $error("chip select width wrong");

  // chip-select form: chip select rises while the write strobe is still low
  property p_cs_form;
    @(posedge clk) disable iff (reset)
      (useChipSel && active && cnt == 4'h0 && isWr) |=> chipSelN && !writeEnN;
  endproperty
  a_cs_form: assert property (p_cs_form)
    else $error("chip select did not end the cycle");
  c_wr_cycle: cover property (@(posedge clk) disable iff (reset) $fell(writeEnN));
endmodule : fwec_strobe

/* logic/fwec_host.sv */
`timescale 1ns/10ps
// host sequencer: program or erase one location and poll for completion
module fwec_host #(
  parameter int     AW          = 18,
  parameter int     DW          = 16,
  parameter longint SMALL_TMO   = fwec_pkg::SMALL_TMO_CYC,
  parameter longint MAIN_TMO    = fwec_pkg::MAIN_TMO_CYC,
  parameter int     RST_REC     = fwec_pkg::RST_REC_CYC
) (
  input  wire logic          clk,
  input  wire logic          reset,
  input  wire logic          opStart,
  input  wire fwec_pkg::fwec_op_t opKind,
  input  wire logic [AW-1:0] opAddr,
  input  wire logic [DW-1:0] opData,
  input  wire logic          opBoot,
  input  wire logic          useChipSel,
  input  wire logic          wideMode,
  output logic               opBusy,
  output logic               opDone,
  output logic               opTimeout,
  output logic [7:0]         opStatus,
  output logic [AW-1:0]      flashAddr,
  output logic               chipSelN,
  output logic               writeEnN,
  output logic               outEnN,
  output logic               resetPowerdownN,
  output logic               writeProtect,
  output logic               byteSelN,
  output logic [DW-1:0]      dataOut,
  output logic               dataOe,
  input  wire logic [DW-1:0] dataIn
);
  typedef enum logic [3:0] {
    FWEC_RECOVER, FWEC_IDLE, FWEC_UNLOCK, FWEC_SETUP, FWEC_CONFIRM,
    FWEC_WAITBUSY, FWEC_STATCMD, FWEC_POLL, FWEC_CHECK, FWEC_FINISH
  } fwec_st_t;

  fwec_st_t state;               // sequencer state
  fwec_cyc_if cyc ();            // link to strobe engine
  logic [31:0] timer;            // short delays
  logic [31:0] tmoCnt;           // long operation timeout count
  logic [31:0] tmoLimit;         // selected timeout for the operation
  fwec_pkg::fwec_op_t kind;      // operation kind latched at start
  logic        isBoot;           // boot block target latched
  logic [DW-1:0] data;           // program data latched
  logic        issued;           // cycle request already given this state

  // strobe engine does the pin-level timing
  fwec_strobe #(.DW(DW)) u_strobe (
    .clk        (clk),
    .reset      (reset),
    .cyc        (cyc.eng),
    .useChipSel (useChipSel),
    .chipSelN   (chipSelN),
    .writeEnN   (writeEnN),
    .outEnN     (outEnN),
    .dataOut    (dataOut),
    .dataOe     (dataOe),
    .dataIn     (dataIn)
  );

  // timeout covers the longest documented duration; program uses the small limit
  always_comb begin
    unique case (kind)
      fwec_pkg::FWEC_ERASE_MAIN: tmoLimit = 32'(MAIN_TMO);
      default:                   tmoLimit = 32'(SMALL_TMO);
    endcase
  end

  // width select: commands stay 8 bits in either mode
  assign byteSelN = wideMode;

  // cycle requests follow the state
  always_comb begin
    cyc.req     = 1'b0;
    cyc.isWrite = 1'b1;
    cyc.wdata   = 16'h0000;
    unique case (state)
      FWEC_SETUP: begin
        cyc.req   = !issued;
        cyc.wdata = {8'h00, (kind == fwec_pkg::FWEC_PROGRAM) ?
                     fwec_pkg::CMD_PROGRAM : fwec_pkg::CMD_ERASE};
      end
      FWEC_CONFIRM: begin
        cyc.req   = !issued;
        cyc.wdata = (kind == fwec_pkg::FWEC_PROGRAM) ? 16'(data) :
                    {8'h00, fwec_pkg::CMD_CONFIRM};
      end
      FWEC_STATCMD: begin
        cyc.req   = !issued;
        cyc.wdata = {8'h00, fwec_pkg::CMD_STATUS};
      end
      FWEC_POLL: begin
        cyc.req     = !issued;
        cyc.isWrite = 1'b0;
      end
      default: begin
        cyc.req = 1'b0;
      end
    endcase
  end

  // main sequence
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state     <= FWEC_RECOVER;
      timer     <= 32'(RST_REC);
      tmoCnt    <= 32'h0000_0000;
      kind      <= fwec_pkg::FWEC_PROGRAM;
      isBoot    <= 1'b0;
      data      <= '0;
      issued    <= 1'b0;
      flashAddr <= '0;
      opStatus  <= 8'h00;
      opDone    <= 1'b0;
      opTimeout <= 1'b0;
    end else begin
      opDone    <= 1'b0;
      issued    <= (cyc.req || issued) && !cyc.done;
      if (state != FWEC_IDLE && state != FWEC_RECOVER) begin
        tmoCnt <= tmoCnt + 32'h1;
      end
      unique case (state)
        FWEC_RECOVER: begin
          if (timer == 32'h0) state <= FWEC_IDLE;
          else timer <= timer - 32'h1;
        end
        FWEC_IDLE: begin
          tmoCnt <= 32'h0;
          if (opStart) begin
            kind      <= opKind;
            isBoot    <= opBoot;
            data      <= opData;
            // address held for the whole operation
            flashAddr <= opAddr;
            opTimeout <= 1'b0;
            timer     <= 32'(fwec_pkg::UNLOCK_SU_CYC);
            state     <= opBoot ? FWEC_UNLOCK : FWEC_SETUP;
          end
        end
        FWEC_UNLOCK: begin
          if (timer == 32'h0) state <= FWEC_SETUP;
          else timer <= timer - 32'h1;
        end
        FWEC_SETUP: if (cyc.done) state <= FWEC_CONFIRM;
        FWEC_CONFIRM: begin
          if (cyc.done) begin
            state <= FWEC_WAITBUSY;
            timer <= 32'(fwec_pkg::BUSY_DLY_CYC);
          end
        end
        FWEC_WAITBUSY: begin
          if (timer == 32'h0) state <= FWEC_STATCMD;
          else timer <= timer - 32'h1;
        end
        FWEC_STATCMD: if (cyc.done) state <= FWEC_POLL;
        FWEC_POLL: if (cyc.done) state <= FWEC_CHECK;
        FWEC_CHECK: begin
          opStatus <= cyc.rdata[7:0];
          if (cyc.rdata[fwec_pkg::STAT_DONE_BIT]) begin
            state <= FWEC_FINISH;
          end else if (tmoCnt >= tmoLimit) begin
            opTimeout <= 1'b1;
            state     <= FWEC_FINISH;
          end else begin
            state <= FWEC_POLL;
          end
        end
        FWEC_FINISH: begin
          opDone <= 1'b1;
          state  <= FWEC_IDLE;
        end
      endcase
    end
  end

  // unlock held until status is valid
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      writeProtect    <= 1'b0;
      resetPowerdownN <= 1'b0;
    end else begin
      resetPowerdownN <= 1'b1;
      writeProtect    <= isBoot && state inside {FWEC_UNLOCK, FWEC_SETUP, FWEC_CONFIRM,
                         FWEC_WAITBUSY, FWEC_STATCMD, FWEC_POLL, FWEC_CHECK};
    end
  end

  assign opBusy = (state != FWEC_IDLE);

  // no strobe before reset recovery ends
  property p_recover;
    @(posedge clk) disable iff (reset)
      (state == FWEC_RECOVER) |-> chipSelN;
  endproperty
  a_recover: assert property (p_recover)
    else $error("strobe during reset recovery");

  // poll read only after busy delay
  property p_wait_busy;
    @(posedge clk) disable iff (reset)
      $rose(state == FWEC_WAITBUSY) |-> (state == FWEC_WAITBUSY) [*5];
  endproperty
  a_wait_busy: assert property (p_wait_busy)
    else $error("status polled too early");

  // unlock present whenever a boot cycle strobes
  property p_unlock_hold;
    @(posedge clk) disable iff (reset)
      (isBoot && !chipSelN && state != FWEC_IDLE) |-> writeProtect;
  endproperty
  a_unlock_hold: assert property (p_unlock_hold)
    else $error("boot unlock dropped early");

  // address stable through the operation
  property p_addr_stable;
    @(posedge clk) disable iff (reset)
      (opBusy && $past(opBusy) && state != FWEC_IDLE) |-> $stable(flashAddr);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address moved during operation");

  // done follows a completed check
  property p_done;
    @(posedge clk) disable iff (reset)
      (state == FWEC_FINISH) |=> opDone && state == FWEC_IDLE;
  endproperty
  a_done: assert property (p_done)
    else $error("done pulse missing");

  // setup and status commands stay one byte wide whatever the width mode
  property p_width;
    @(posedge clk) disable iff (reset)
      (dataOe && state inside {FWEC_SETUP, FWEC_STATCMD}) |-> (dataOut >> 8) == '0;
  endproperty
  a_width: assert property (p_width)
    else $error("command wider than a byte");

  // unlock setup time before first strobe
  property p_unlock_su;
    @(posedge clk) disable iff (reset)
      $rose(state == FWEC_UNLOCK) |-> (state == FWEC_UNLOCK) [*5];
  endproperty
  a_unlock_su: assert property (p_unlock_su)
    else $error("unlock setup too short");

  // reset pin released after reset
  property p_rpn;
    @(posedge clk) disable iff (reset) (state == FWEC_IDLE) |-> resetPowerdownN;
  endproperty
  a_rpn: assert property (p_rpn)
    else $error("reset pin low when idle");

  c_program: cover property (@(posedge clk) disable iff (reset)
    opDone && kind == fwec_pkg::FWEC_PROGRAM);
  c_boot: cover property (@(posedge clk) disable iff (reset) opDone && isBoot);
  c_timeout: cover property (@(posedge clk) disable iff (reset) $rose(opTimeout));
endmodule : fwec_host

/* tb/fwec_flash_model.sv */
`timescale 1ns/10ps
// behavioural flash device seen from the host pins
module fwec_flash_model #(
  parameter int            AW         = 18,
  parameter int            DW         = 16,
  parameter int            BUSY_NS    = 200,       // strobe end to busy shown, slow case
  parameter int            PGM_NS     = 6000,      // word or byte program
  parameter int            SMALL_NS   = 8000,      // boot/parameter erase, shortened
  parameter int            MAIN_NS    = 12000,     // main erase, shortened
  parameter logic [AW-1:0] SMALL_BASE = 18'h3C000, // first boot/parameter address
  parameter logic [AW-1:0] BOOT_BASE  = 18'h3E000, // first boot block address
  parameter logic [7:0]    LOCK_STAT  = 8'h92      // status after a refused boot write
) (
  input  wire logic [AW-1:0] flashAddr,
  input  wire logic          chipSelN,
  input  wire logic          writeEnN,
  input  wire logic          outEnN,
  input  wire logic          resetPowerdownN,
  input  wire logic          writeProtect,
  input  wire logic          byteSelN,
  input  wire logic [DW-1:0] dataOut,
  input  wire logic          dataOe,
  output logic [DW-1:0]      dataIn,
  input  wire logic          stall      // keeps the device busy, for timeout tests
);
  // either strobe
  // a cycle is open while both strobes are low, whichever rises first ends it
  logic            strobeN;
  logic            rdEn;       // status or array read in progress
  logic [DW-1:0]   rdVal;      // value shown while read enabled
  logic [DW-1:0]   latchData;  // data seen during the strobe low phase
  logic [DW-1:0]   lastOut;    // last value driven, inverted once released
  logic [DW-1:0]   lastData;   // last programmed word
  logic [AW-1:0]   lastAddr;   // target of the last operation
  logic [AW-1:0]   addrLow;    // address just after the strobe fell
  logic [7:0]      statReg = 8'h80;
  logic [7:0]      cmd;
  logic            statMode = 1'b0;
  logic            inCycle = 1'b0;
  logic            bootBusy = 1'b0;
  logic [1:0]      pend = 2'd0; // 1 program armed, 2 erase armed
  int              opSeq = 0;     // bumped by reset so stale operations die
  int              opCount = 0;
  int              violCount = 0; // host timing faults seen
  realtime         tRel = 0.0;
  realtime         tEnd = -1.0e6;
  assign strobeN = chipSelN | writeEnN;
  assign rdEn    = !chipSelN && !outEnN && writeEnN;
  assign rdVal   = statMode ? DW'(statReg) : lastData;
  // released bus shows the inverse of the last value, never a stable guess
  assign dataIn  = rdEn ? rdVal : ~lastOut;
  always @(negedge rdEn) lastOut = rdVal;
  always @(*) if (!strobeN && dataOe) latchData = dataOut;
  always @(posedge resetPowerdownN) tRel = $realtime;
  // reset pin aborts everything
  always @(negedge resetPowerdownN) begin
    opSeq++;
    pend = 2'd0;
    statMode = 1'b0;
    statReg = 8'h80;
    bootBusy = 1'b0;
  end
  always @(negedge strobeN) begin
    inCycle = 1'b1;
    if (resetPowerdownN !== 1'b1 || $realtime - tRel < 1000.0) violCount++;
    #5 addrLow = flashAddr;
  end
  always @(posedge rdEn) if (statMode && $realtime - tEnd < BUSY_NS) violCount++;
  always @(negedge writeProtect) if (bootBusy) violCount++;
  task automatic run_op(input int seq, input int durNs, input logic locked);
    #(BUSY_NS);
    if (seq == opSeq) statReg[7] = 1'b0;
    #(durNs - BUSY_NS);
    wait (!stall || seq != opSeq);
    if (seq == opSeq) begin
      statReg = locked ? LOCK_STAT : 8'h80;
      bootBusy = 1'b0;
    end
  endtask : run_op
  // unlock check at operation start
  // the pin is looked at when the operation starts; a relock while a boot operation runs counts as a host fault
  task automatic start_op(input int durNs);
    logic lk;
    lk = (flashAddr >= BOOT_BASE) && !writeProtect;
    bootBusy = (flashAddr >= BOOT_BASE) && !lk;
    lastAddr = flashAddr;
    opCount++;
    pend = 2'd0;
    statMode = 1'b1;
    tEnd = $realtime;
    fork
      run_op(opSeq, durNs, lk);
    join_none
  endtask : start_op
  // command decode at the end of each write cycle
  always @(posedge strobeN) if (inCycle) begin
    inCycle = 1'b0;
    if (flashAddr !== addrLow) violCount++;
    cmd = latchData[7:0];
    if (pend == 2'd1) begin
      lastData = byteSelN ? latchData : {8'h00, latchData[7:0]};
      start_op(PGM_NS);
    end else if (pend == 2'd2 && cmd == 8'hD0) begin
      start_op(flashAddr < SMALL_BASE ? MAIN_NS : SMALL_NS);
    end else begin
      case (cmd)
        8'h40:   pend = 2'd1;
        8'h20:   pend = 2'd2;
        8'h70:   statMode = 1'b1;
        8'h50:   statReg[6:0] = 7'h00;
        8'hFF:   statMode = 1'b0;
        default: pend = 2'd0;
      endcase
    end
  end
endmodule : fwec_flash_model

/* tb/flash_write_erase_cycle_bench.sv */
`timescale 1ns/10ps
`define CHECK(got, exp, msg) begin checkCount++; if ((got) !== (exp)) begin errors++; \
  $display("wrong value at %0t ns: %s", $time, msg); end end
// drives the host sequencer against the device model
module flash_write_erase_cycle_bench;
  logic                 clk = 1'b0;
  logic                 reset = 1'b1;
  logic                 opStart = 1'b0;
  fwec_pkg::fwec_op_t   opKind = fwec_pkg::FWEC_PROGRAM;
  logic [17:0]          opAddr = 18'h00000;
  logic [15:0]          opData = 16'h0000;
  logic                 opBoot = 1'b0;
  logic                 useChipSel = 1'b0;
  logic                 wideMode = 1'b1;
  logic                 stall = 1'b0;
  logic                 opBusy, opDone, opTimeout, chipSelN, writeEnN, outEnN;
  logic                 resetPowerdownN, writeProtect, byteSelN, dataOe;
  logic [7:0]           opStatus;
  logic [17:0]          flashAddr;
  logic [15:0]          dataOut, dataIn;
  int                   errors = 0;
  int                   checkCount = 0;
  int                   cyc;
  // timeouts shortened so a stalled device is caught quickly
  fwec_host #(.SMALL_TMO(64'h190), .MAIN_TMO(64'h258)) dut_u (
    .clk(clk), .reset(reset), .opStart(opStart), .opKind(opKind), .opAddr(opAddr),
    .opData(opData), .opBoot(opBoot), .useChipSel(useChipSel), .wideMode(wideMode),
    .opBusy(opBusy), .opDone(opDone), .opTimeout(opTimeout), .opStatus(opStatus),
    .flashAddr(flashAddr), .chipSelN(chipSelN), .writeEnN(writeEnN), .outEnN(outEnN),
    .resetPowerdownN(resetPowerdownN), .writeProtect(writeProtect), .byteSelN(byteSelN),
    .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn));
  fwec_flash_model dev_u (
    .flashAddr(flashAddr), .chipSelN(chipSelN), .writeEnN(writeEnN), .outEnN(outEnN),
    .resetPowerdownN(resetPowerdownN), .writeProtect(writeProtect), .byteSelN(byteSelN),
    .dataOut(dataOut), .dataOe(dataOe), .dataIn(dataIn), .stall(stall));
  // 25 MHz clock
  initial begin
    forever #20 clk = ~clk;
  end
  task give_verdict;
    $display("comparisons %0d, mismatches %0d", checkCount, errors);
    if (errors == 0 && checkCount > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : give_verdict
  // one operation, counted in cycles from the taking edge to done or timeout
  task do_op(input fwec_pkg::fwec_op_t k, input logic [17:0] a, input logic [15:0] d,
             input logic b, input logic cs, input logic w);
    @(posedge clk);
    #2;
    opKind = k;
    {opAddr, opData, opBoot, useChipSel, wideMode} = {a, d, b, cs, w};
    opStart = 1'b1;
    @(posedge clk);
    #2;
    opStart = 1'b0;
    cyc = 1;
    while (opDone !== 1'b1 && opTimeout !== 1'b1 && cyc < 900) begin
      @(posedge clk);
      #1;
      cyc++;
    end
    `CHECK(cyc < 900, 1'b1, "operation hung")
  endtask : do_op
  task wait_idle;
    int n;
    n = 0;
    while (opBusy !== 1'b0 && n < 100) begin
      @(posedge clk);
      #1;
      n++;
    end
    `CHECK(opBusy, 1'b0, "host never idle")
  endtask : wait_idle
  // back-to-back programs over both strobe forms and both widths
  task test_program;
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      d = 16'hA55A ^ 16'(i * 16'h1111);
      do_op(fwec_pkg::FWEC_PROGRAM, 18'h01230 + 18'(i), d, 1'b0, i[0], i[1]);
      `CHECK(opStatus, 8'h80, "program status")
      `CHECK(cyc >= 150, 1'b1, "program too short")
      `CHECK(byteSelN, i[1], "width pin")
      `CHECK(dev_u.lastData, i[1] ? d : {8'h00, d[7:0]}, "programmed word")
      `CHECK(dev_u.lastAddr, 18'h01230 + 18'(i), "program address")
    end
    $display("program test done");
  endtask : test_program
  // small and main block erase lengths
  task test_erase;
    do_op(fwec_pkg::FWEC_ERASE_SMALL, 18'h3C100, 16'h0000, 1'b0, 1'b1, 1'b1);
    `CHECK(opStatus, 8'h80, "small erase status")
    `CHECK(cyc >= 200, 1'b1, "small erase too short")
    `CHECK(opTimeout, 1'b0, "small erase timed out")
    do_op(fwec_pkg::FWEC_ERASE_MAIN, 18'h00100, 16'h0000, 1'b0, 1'b0, 1'b1);
    `CHECK(opStatus, 8'h80, "main erase status")
    `CHECK(cyc >= 300, 1'b1, "main erase too short")
    `CHECK(opTimeout, 1'b0, "main erase timed out")
    $display("erase test done");
  endtask : test_erase
  // boot block with and without unlock
  task test_boot;
    do_op(fwec_pkg::FWEC_PROGRAM, 18'h3E010, 16'h1234, 1'b1, 1'b0, 1'b1);
    `CHECK(opStatus, 8'h80, "unlocked boot program")
    repeat (8) @(posedge clk);
    `CHECK(writeProtect, 1'b0, "unlock left on")
    do_op(fwec_pkg::FWEC_ERASE_SMALL, 18'h3E000, 16'h0000, 1'b0, 1'b1, 1'b1);
    `CHECK(opStatus, dev_u.LOCK_STAT, "locked boot erase")
    $display("boot test done");
  endtask : test_boot
  // a second start while busy is ignored
  task test_refuse;
    int n0;
    n0 = dev_u.opCount;
    fork
      do_op(fwec_pkg::FWEC_PROGRAM, 18'h00500, 16'hC3C3, 1'b0, 1'b0, 1'b1);
      begin
        repeat (20) @(posedge clk);
        #2;
        {opData, opAddr, opStart} = {16'h3C3C, 18'h00600, 1'b1};
        @(posedge clk);
        #2;
        opStart = 1'b0;
      end
    join
    repeat (10) @(posedge clk);
    `CHECK(dev_u.opCount - n0, 1, "extra operation")
    `CHECK(dev_u.lastData, 16'hC3C3, "data changed mid op")
    $display("refuse test done");
  endtask : test_refuse
  // stuck device, timeout, then reset mid run and recover
  task test_timeout;
    stall = 1'b1;
    do_op(fwec_pkg::FWEC_ERASE_SMALL, 18'h3C200, 16'h0000, 1'b0, 1'b0, 1'b1);
    `CHECK(opTimeout, 1'b1, "no timeout")
    `CHECK(cyc >= 400, 1'b1, "timeout too early")
    @(posedge clk);
    #2;
    reset = 1'b1;
    repeat (3) @(posedge clk);
    #2;
    {reset, stall} = 2'b00;
    #1;
    `CHECK(opBusy, 1'b1, "recovery not busy")
    wait_idle();
    do_op(fwec_pkg::FWEC_PROGRAM, 18'h00700, 16'h0F0F, 1'b0, 1'b1, 1'b0);
    `CHECK(opStatus, 8'h80, "program after reset")
    `CHECK(opTimeout, 1'b0, "timeout not cleared")
    $display("timeout test done");
  endtask : test_timeout
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    #2;
    reset = 1'b0;
    wait_idle();
    test_program();
    test_erase();
    test_boot();
    test_refuse();
    test_timeout();
    `CHECK(dev_u.violCount, 0, "host timing fault")
    give_verdict();
  end
  // watchdog far beyond the expected run of a few thousand cycles
  initial begin
    #1000000;
    errors++;
    give_verdict();
  end
endmodule : flash_write_erase_cycle_bench
